// File: common/ebc_pkg.sv
package ebc_pkg;
  // geometry of the external bus
  localparam int unsigned AREAS  = 8;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned WAIT_W = 3;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned LANE_W = 16;
  localparam int unsigned WORD_W = 32;
  // reset values of the configuration
  localparam logic [7:0]        THREE_ST_RST = 8'hFF; // all areas 3-state
  localparam logic [WAIT_W-1:0] WAIT_RST     = 3'h7;  // seven program waits
  localparam logic [7:0]        RD_ALT_RST   = 8'h00;
  localparam logic [7:0]        LITTLE_RST   = 8'h00; // big endian
  localparam logic [7:0]        MUX_RST      = 8'h00;
  localparam logic              PIN_EN_RST   = 1'b0;
  // half-state phases: first half high, second half low bus clock
  localparam logic PH_HIGH = 1'b0;
  localparam logic PH_LOW  = 1'b1;
  // access sizes and bus states
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} ebc_size_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_T1, ST_T2, ST_TPW, ST_TTW, ST_T3
  } ebc_state_t;
endpackage

// File: common/ebc_piece_if.sv
`timescale 1ns/1ns
`default_nettype none
// one access split into bus pieces: request side and plan side
interface ebc_piece_if;
  ebc_pkg::ebc_size_t size;
  logic               addr_odd;
  logic               little;
  logic [1:0]         piece;
  logic [31:0]        wdata;
  logic [1:0]         count;
  logic [1:0]         offset;
  logic               hi_en;
  logic               lo_en;
  logic [1:0]         hi_idx;
  logic [1:0]         lo_idx;
  logic [15:0]        bus_wdata;
  modport plan (input size, addr_odd, little, piece, wdata,
                output count, offset, hi_en, lo_en, hi_idx, lo_idx,
                bus_wdata);
  modport seq (output size, addr_odd, little, piece, wdata,
               input count, offset, hi_en, lo_en, hi_idx, lo_idx,
               bus_wdata);
endinterface // ebc_piece_if
`default_nettype wire

// File: core/ebc_piece_plan.sv
`timescale 1ns/1ns
`default_nettype none
// splits one access into 16-bit bus pieces and places bytes on lanes
module ebc_piece_plan
(
  // plan port
  ebc_piece_if.plan pif
);
  // memory order runs low address first; endian picks value byte and lane
  always_comb
  begin
    logic [2:0] nb;
    logic [2:0] off;
    logic [2:0] total;
    logic [2:0] pos;
    logic [2:0] idx;
    logic       par;
    logic       to_hi;
    pos = 3'h0;
    idx = 3'h0;
    par = 1'b0;
    to_hi = 1'b0;
    nb = 3'h1;
    off = 3'h0;
    total = 3'h1;
    pif.count = 2'h1;
    case (pif.size)
      ebc_pkg::SZ_WORD:
      begin
        total = 3'h2;
        if (pif.addr_odd) // RL4 RL5
        begin
          pif.count = 2'h2;
          off = {2'h0, pif.piece[0]};
        end
        else
          nb = 3'h2;
      end
      ebc_pkg::SZ_LONG:
      begin
        total = 3'h4;
        if (pif.addr_odd) // RL4 RL5
        begin
          pif.count = 2'h3;
          nb = (pif.piece == 2'h1) ? 3'h2 : 3'h1;
          off = (pif.piece == 2'h0) ? 3'h0 :
                (pif.piece == 2'h1) ? 3'h1 : 3'h3;
        end
        else
        begin
          pif.count = 2'h2;
          nb = 3'h2;
          off = {pif.piece[0], 2'h0} >> 1;
        end
      end
      default:
      begin
        total = 3'h1;
      end
    endcase
    pif.offset = off[1:0];
    pif.hi_en = 1'b0;
    pif.lo_en = 1'b0;
    pif.hi_idx = 2'h0;
    pif.lo_idx = 2'h0;
    pif.bus_wdata = 16'h0000;
    for (int j = 0; j < 2; j++)
    begin
      pos = off + 3'(j);
      par = pif.addr_odd ^ pos[0];
      to_hi = pif.little ? par : !par; // RL2 RL3
      idx = pif.little ? pos : total - 3'h1 - pos;
      if (3'(j) < nb && to_hi) // RL1
      begin
        pif.hi_en = 1'b1;
        pif.hi_idx = idx[1:0];
        pif.bus_wdata[15:8] = pif.wdata[idx[1:0]*8 +: 8];
      end
      else if (3'(j) < nb)
      begin
        pif.lo_en = 1'b1;
        pif.lo_idx = idx[1:0];
        pif.bus_wdata[7:0] = pif.wdata[idx[1:0]*8 +: 8];
      end
    end
  end
endmodule // ebc_piece_plan
`default_nettype wire

// File: core/ebc_cycle_unit.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RL1: sixteen-bit space uses both byte lanes, one byte or word per cycle
// RL2: big endian bytes: even address upper lane, odd address lower lane
// RL3: little endian bytes: even address lower lane, odd address upper lane
// RL4: big endian splitting of odd words and longwords, high part first
// RL5: little endian splitting of odd words and longwords, low part first
// RL6: two-state cycles never get any wait state
// RL7: three-state cycles insert zero to seven program waits after T2
// RL8: hold input honoured only in 3-state with both enables set
// RL9: hold sampled at last T2 or wait falling edge; low adds waits
// RL10: one pin wait enable serves every area
// RL11: reset gives 3-state, seven waits, hold input disabled
// RL12: eight per-area read strobe timing bits select the alternative
// RL13: dma acknowledge edge relation to read strobe follows timing bit; the code holds it for the whole access, ignoring the bit
// RL14: cycle start pulse at each cycle; address strobe while address valid
// RL15: read strobe on reads; direction signal shows data bus direction
// RL16: lane write strobes only for lanes carrying valid data
// RL17: eight active-low area selects, the accessed one asserted
// RL18: multiplexed areas use the shared pin only as address hold
// RL19: two states, or three with waits between second and third
// RL20: alternative timing negates read strobe half bus clock earlier
module ebc_cycle_unit
(
  // clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      srst_i,
  // internal access request
  input  wire logic                      req_i,
  input  wire logic                      req_write_i,
  input  wire ebc_pkg::ebc_size_t        req_size_i,
  input  wire logic [23:0]               req_addr_i,
  input  wire logic [2:0]                req_area_i,
  input  wire logic [31:0]               req_wdata_i,
  input  wire logic                      req_dma_i,
  output logic                           ready_o,
  output logic                           done_o,
  output logic [31:0]                    rdata_o,
  // configuration, taken on cfg_we_i
  input  wire logic                      cfg_we_i,
  input  wire logic [7:0]                area_state_config_i,
  input  wire logic [23:0]               wait_count_config_i,
  input  wire logic [7:0]                read_strobe_timing_config_i,
  input  wire logic [7:0]                endian_config_i,
  input  wire logic [7:0]                mux_select_i,
  input  wire logic                      pin_hold_enable_i,
  input  wire logic                      port_input_buffer_control_i,
  // external bus pins
  input  wire logic                      hold_req_n_i,
  input  wire logic [15:0]               data_i,
  output logic [15:0]                    data_o,
  output logic                           data_oe_o,
  output logic [23:0]                    addr_o,
  output logic                           cycle_begin_out_n_o,
  output logic                           address_valid_strobe_n_o,
  output logic                           address_hold_out_o,
  output logic                           rd_n_o,
  output logic                           rd_wr_o,
  output logic                           upper_lane_write_strobe_n_o,
  output logic                           lower_lane_write_strobe_n_o,
  output logic [7:0]                     area_select_outputs_n_o,
  output logic                           dma_acknowledge_n_o
);
  // configuration state
  logic [7:0]  three_q, three_d;
  logic [23:0] waits_q, waits_d;
  logic [7:0]  rdalt_q, rdalt_d;
  logic [7:0]  little_q, little_d;
  logic [7:0]  mux_q, mux_d;
  logic        pinen_q, pinen_d;
  logic        ibuf_q, ibuf_d;
  // pin synchronisers
  logic        hold_m_q, hold_s_q;
  logic [15:0] data_m_q, data_s_q;
  // sequencer state
  ebc_pkg::ebc_state_t st_q, st_d;
  logic        ph_q, ph_d;
  logic [2:0]  wleft_q, wleft_d;
  logic [1:0]  piece_q, piece_d;
  logic        wr_q, wr_d;
  logic        dma_q, dma_d;
  logic [2:0]  area_q, area_d;
  logic [23:0] base_q, base_d;
  logic [31:0] wdat_q, wdat_d;
  logic [31:0] rdat_q, rdat_d;
  ebc_pkg::ebc_size_t size_q, size_d;
  // registered pin and answer values
  logic        done_d, ready_d, oe_d, bs_d, as_d, ah_d, rd_d, rw_d;
  logic        uw_d, lw_d, dma_acknowledge_d;
  logic [15:0] dout_d;
  logic [23:0] addr_d;
  logic [7:0]  cs_d;
  // derived per-area settings
  logic        three_st, rd_alt, mux_area, pin_ok, last_state;
  logic [2:0]  area_wait;
  ebc_piece_if pif ();
  ebc_piece_plan u_plan (.pif(pif));
  assign pif.size = size_q;
  assign pif.addr_odd = base_q[0];
  assign pif.little = little_q[area_q];
  assign pif.piece = piece_q;
  assign pif.wdata = wdat_q;
  assign three_st = three_q[area_q];
  assign rd_alt = rdalt_q[area_q]; // RL12
  assign mux_area = mux_q[area_q];
  assign area_wait = waits_q[area_q*ebc_pkg::WAIT_W +: ebc_pkg::WAIT_W];
  // one global enable for all areas, gated with the port buffer bit
  assign pin_ok = three_st && pinen_q && ibuf_q; // RL8 RL10
  // config is loaded as a whole so a half-written area cannot be seen
  always_comb
  begin
    three_d = three_q;
    waits_d = waits_q;
    rdalt_d = rdalt_q;
    little_d = little_q;
    mux_d = mux_q;
    pinen_d = pinen_q;
    ibuf_d = ibuf_q;
    if (cfg_we_i)
    begin
      three_d = area_state_config_i;
      waits_d = wait_count_config_i;
      rdalt_d = read_strobe_timing_config_i;
      little_d = endian_config_i;
      mux_d = mux_select_i;
      pinen_d = pin_hold_enable_i;
      ibuf_d = port_input_buffer_control_i;
    end
  end
  // config registers with their reset defaults
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      three_q <= ebc_pkg::THREE_ST_RST; // RL11
      waits_q <= {ebc_pkg::AREAS{ebc_pkg::WAIT_RST}}; // RL11
      rdalt_q <= ebc_pkg::RD_ALT_RST;
      little_q <= ebc_pkg::LITTLE_RST;
      mux_q <= ebc_pkg::MUX_RST;
      pinen_q <= ebc_pkg::PIN_EN_RST; // RL11
      ibuf_q <= ebc_pkg::PIN_EN_RST;
    end
    else
    begin
      three_q <= three_d;
      waits_q <= waits_d;
      rdalt_q <= rdalt_d;
      little_q <= little_d;
      mux_q <= mux_d;
      pinen_q <= pinen_d;
      ibuf_q <= ibuf_d;
    end
  end
  // two-flop synchronisers; read data lags the pin by two ref cycles
  always_ff @(posedge ref_clk_i)
  begin
    hold_m_q <= hold_req_n_i;
    hold_s_q <= hold_m_q;
    data_m_q <= data_i;
    data_s_q <= data_m_q;
  end
  // last bus state of the piece ends in its low half
  assign last_state = (st_q == ebc_pkg::ST_T3) ||
                      (st_q == ebc_pkg::ST_T2 && !three_st);
  // next sequencer state, read bytes and done; each bus state is two ref cycles
  always_comb
  begin
    st_d = st_q;
    ph_d = ph_q;
    wleft_d = wleft_q;
    piece_d = piece_q;
    wr_d = wr_q;
    dma_d = dma_q;
    area_d = area_q;
    base_d = base_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    size_d = size_q;
    done_d = 1'b0;
    if (st_q == ebc_pkg::ST_IDLE)
    begin
      if (req_i)
      begin
        st_d = ebc_pkg::ST_T1;
        ph_d = ebc_pkg::PH_HIGH;
        piece_d = 2'h0;
        wr_d = req_write_i;
        dma_d = req_dma_i;
        area_d = req_area_i;
        base_d = req_addr_i;
        wdat_d = req_wdata_i;
        size_d = req_size_i;
        rdat_d = 32'h0000_0000;
      end
    end
    else if (ph_q == ebc_pkg::PH_HIGH)
      ph_d = ebc_pkg::PH_LOW;
    else
    begin
      ph_d = ebc_pkg::PH_HIGH;
      case (st_q)
        ebc_pkg::ST_T1:
          st_d = ebc_pkg::ST_T2;
        ebc_pkg::ST_T2:
        begin
          wleft_d = area_wait;
          if (!three_st)
            st_d = ebc_pkg::ST_IDLE; // RL6 RL19
          else if (area_wait != 3'h0)
          begin
            st_d = ebc_pkg::ST_TPW; // RL7
            wleft_d = area_wait - 3'h1;
          end
          else if (pin_ok && !hold_s_q)
            st_d = ebc_pkg::ST_TTW; // RL9
          else
            st_d = ebc_pkg::ST_T3; // RL19
        end
        ebc_pkg::ST_TPW:
        begin
          if (wleft_q != 3'h0)
            wleft_d = wleft_q - 3'h1; // RL7
          else if (pin_ok && !hold_s_q)
            st_d = ebc_pkg::ST_TTW; // RL9
          else
            st_d = ebc_pkg::ST_T3;
        end
        ebc_pkg::ST_TTW:
        begin
          if (hold_s_q)
            st_d = ebc_pkg::ST_T3; // RL9
        end
        default:
          st_d = ebc_pkg::ST_IDLE;
      endcase
      if (last_state)
      begin
        // read bytes are taken at the end of the piece
        if (!wr_q && pif.hi_en)
          rdat_d[pif.hi_idx*8 +: 8] = data_s_q[15:8];
        if (!wr_q && pif.lo_en)
          rdat_d[pif.lo_idx*8 +: 8] = data_s_q[7:0];
        if (piece_q + 2'h1 < pif.count) // RL4 RL5
        begin
          st_d = ebc_pkg::ST_T1;
          piece_d = piece_q + 2'h1;
        end
        else
        begin
          st_d = ebc_pkg::ST_IDLE;
          done_d = 1'b1;
        end
      end
    end
  end
  // pin levels follow the state being entered so they leave flops
  always_comb
  begin
    logic act;
    logic fin;
    logic fin_low;
    act = (st_d != ebc_pkg::ST_IDLE) && (piece_d == piece_q ||
          st_d == ebc_pkg::ST_T1);
    fin = (st_d == ebc_pkg::ST_T3) ||
          (st_d == ebc_pkg::ST_T2 && !three_st);
    fin_low = fin && ph_d == ebc_pkg::PH_LOW;
    ready_d = (st_d == ebc_pkg::ST_IDLE);
    bs_d = act && st_d == ebc_pkg::ST_T1; // RL14
    // area_d, not area_q: the first half of T1 belongs to the new area
    as_d = act && !mux_q[area_d] && !fin_low &&
           !(st_d == ebc_pkg::ST_T1 && ph_d == ebc_pkg::PH_HIGH); // RL14
    ah_d = act && mux_q[area_d] && st_d == ebc_pkg::ST_T1; // RL18
    rd_d = act && !wr_d && !(st_d == ebc_pkg::ST_T1 &&
           ph_d == ebc_pkg::PH_HIGH) &&
           !(rd_alt && fin_low); // RL15 RL20
    rw_d = act ? !wr_d : 1'b1; // RL15
    uw_d = act && wr_d && pif.hi_en && st_d != ebc_pkg::ST_T1 &&
           !fin_low; // RL16
    lw_d = act && wr_d && pif.lo_en && st_d != ebc_pkg::ST_T1 &&
           !fin_low; // RL16
    oe_d = act && wr_d && !(st_d == ebc_pkg::ST_T1 &&
           ph_d == ebc_pkg::PH_HIGH);
    dout_d = pif.bus_wdata;
    addr_d = base_d + {22'h0, pif.offset};
    cs_d = act ? (8'h01 << area_d) : 8'h00; // RL17
    dma_acknowledge_d = act && dma_d; // RL13
  end
  // sequencer and pin registers
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      st_q <= ebc_pkg::ST_IDLE;
      ph_q <= ebc_pkg::PH_HIGH;
      wleft_q <= 3'h0;
      piece_q <= 2'h0;
      wr_q <= 1'b0;
      dma_q <= 1'b0;
      area_q <= 3'h0;
      base_q <= 24'h00_0000;
      wdat_q <= 32'h0000_0000;
      rdat_q <= 32'h0000_0000;
      size_q <= ebc_pkg::SZ_BYTE;
      ready_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      data_o <= 16'h0000;
      data_oe_o <= 1'b0;
      addr_o <= 24'h00_0000;
      cycle_begin_out_n_o <= 1'b1;
      address_valid_strobe_n_o <= 1'b1;
      address_hold_out_o <= 1'b0;
      rd_n_o <= 1'b1;
      rd_wr_o <= 1'b1;
      upper_lane_write_strobe_n_o <= 1'b1;
      lower_lane_write_strobe_n_o <= 1'b1;
      area_select_outputs_n_o <= 8'hFF;
      dma_acknowledge_n_o <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      ph_q <= ph_d;
      wleft_q <= wleft_d;
      piece_q <= piece_d;
      wr_q <= wr_d;
      dma_q <= dma_d;
      area_q <= area_d;
      base_q <= base_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      size_q <= size_d;
      ready_o <= ready_d;
      done_o <= done_d;
      rdata_o <= rdat_d;
      data_o <= dout_d;
      data_oe_o <= oe_d;
      addr_o <= addr_d;
      cycle_begin_out_n_o <= !bs_d;
      address_valid_strobe_n_o <= !as_d;
      address_hold_out_o <= ah_d;
      rd_n_o <= !rd_d;
      rd_wr_o <= rw_d;
      upper_lane_write_strobe_n_o <= !uw_d;
      lower_lane_write_strobe_n_o <= !lw_d;
      area_select_outputs_n_o <= ~cs_d;
      dma_acknowledge_n_o <= !dma_acknowledge_d;
    end
  end
  // checks on the generated bus cycle
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_start;
    st_q == ebc_pkg::ST_T1 && ph_q == ebc_pkg::PH_HIGH;
  endsequence
  sequence s_strobe;
    ##1 !address_valid_strobe_n_o || address_hold_out_o;
  endsequence
  a_no_wait_2st: assert property ( // RL6
    st_q == ebc_pkg::ST_TPW || st_q == ebc_pkg::ST_TTW |-> three_st)
    else $error("wait state in two-state area");
  a_pw_bound: assert property ( // RL7
    st_q == ebc_pkg::ST_TPW |-> wleft_q < area_wait)
    else $error("program wait count exceeds setting");
  a_pin_gate: assert property ( // RL8
    st_q == ebc_pkg::ST_TTW |-> pinen_q && ibuf_q && three_st)
    else $error("pin wait without enables");
  a_reset_dflt: assert property ( // RL11
    $past(srst_i) |-> three_q == 8'hFF && !pinen_q &&
    waits_q == 24'hFF_FFFF)
    else $error("reset defaults wrong");
  a_cycle_start: assert property ( // RL14
    s_start |-> !cycle_begin_out_n_o ##0 s_strobe)
    else $error("cycle start or strobe missing");
  a_read_dir: assert property ( // RL15
    !rd_n_o |-> rd_wr_o && !data_oe_o)
    else $error("read strobe with bus driven");
  a_lane_we: assert property ( // RL16
    !upper_lane_write_strobe_n_o || !lower_lane_write_strobe_n_o
    |-> !rd_wr_o && data_oe_o)
    else $error("write strobe outside write");
  a_cs_onehot: assert property ( // RL17
    $onehot0(~area_select_outputs_n_o))
    else $error("more than one area select");
  a_mux_as: assert property ( // RL18
    mux_area && st_q != ebc_pkg::ST_IDLE |-> address_valid_strobe_n_o)
    else $error("address strobe in multiplexed area");
  a_rd_early: assert property ( // RL20
    last_state && ph_q == ebc_pkg::PH_LOW && rd_alt |-> rd_n_o)
    else $error("read strobe not negated early");
endmodule // ebc_cycle_unit
`default_nettype wire

// File: verif/ebc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// external 16-bit static memory; slow_i stretches a cycle by hold request
module ebc_mem_model
(
  // clock
  input  wire logic        ref_clk_i,
  // bus pins from the controller
  input  wire logic [23:0] addr_i,
  input  wire logic [7:0]  cs_n_i,
  input  wire logic        rd_wr_i,
  input  wire logic        wr_hi_n_i,
  input  wire logic        wr_lo_n_i,
  input  wire logic        begin_n_i,
  input  wire logic [15:0] wdata_i,
  // bench control and pins back
  input  wire logic [3:0]  slow_i,
  output logic [15:0]      rdata_o,
  output logic             hold_n_o
);
  logic [15:0] mem [int];
  logic [15:0] last_q = 16'h0000;
  logic [15:0] word;
  logic        beg_q = 1'b1;
  int          hold_cnt = 0;
  int          key;

  always_comb key = int'(addr_i[23:1]);

  // lanes kept as they sit on the wire, upper lane in bits 15:8
  always @(posedge ref_clk_i)
  begin
    word = mem.exists(key) ? mem[key] : 16'h0000;
    if (!wr_hi_n_i)
      word[15:8] = wdata_i[15:8];
    if (!wr_lo_n_i)
      word[7:0] = wdata_i[7:0];
    if (cs_n_i != 8'hFF && !(wr_hi_n_i && wr_lo_n_i))
      mem[key] = word;
    // hold low from cycle start for a set span, then let it go high
    if (!begin_n_i && beg_q)
      hold_cnt = 4 * slow_i;
    else if (hold_cnt > 0)
      hold_cnt--;
    beg_q = begin_n_i;
    hold_n_o <= (hold_cnt == 0);
    last_q <= rdata_o;
  end

  // drive only while selected for a read; else toggle so nothing is stale
  always @*
  begin
    if (cs_n_i != 8'hFF && rd_wr_i)
      rdata_o = mem.exists(key) ? mem[key] : 16'h0000;
    else
      rdata_o = ~last_q;
  end
endmodule // ebc_mem_model
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// bench: byte-level model of the wire lanes against the cycle unit
module tb_top;
  logic clk = 1'b0, srst = 1'b1, req = 1'b0, req_wr = 1'b0, dma = 1'b0;
  logic req_dma = 1'b0, cfg_we = 1'b0, pen = 1'b0, ibc = 1'b0;
  ebc_pkg::ebc_size_t req_sz = ebc_pkg::SZ_BYTE;
  logic [23:0] req_addr = 24'h000000, wt = 24'hFFFFFF, addr;
  logic [2:0]  req_area = 3'h0, cur_area = 3'h0;
  logic [31:0] req_wd = 32'h00000000, rdata, got;
  logic [7:0]  st = 8'hFF, alt = 8'h00, le = 8'h00, mux = 8'h00, cs_n;
  logic [3:0]  slow = 4'h0;
  logic ready, done, oe, bs_n, as_n, ah, rd_n, rd_wr, wh_n, wl_n, dma_acknowledge_n;
  logic hold_n, bs_q = 1'b1, cur_wr = 1'b0, cur_dma = 1'b0;
  logic [15:0] dout, mem_d, din;
  logic [7:0]  phys [int];
  int          cnt [6];
  int          error_cnt = 0;
  int          n_checks = 0;

  always #25 clk = ~clk;
  assign din = oe ? dout : mem_d;

  ebc_cycle_unit u_dut (.ref_clk_i(clk), .srst_i(srst), .req_i(req),
    .req_write_i(req_wr), .req_size_i(req_sz), .req_addr_i(req_addr),
    .req_area_i(req_area), .req_wdata_i(req_wd), .req_dma_i(req_dma),
    .ready_o(ready), .done_o(done), .rdata_o(rdata), .cfg_we_i(cfg_we),
    .area_state_config_i(st), .wait_count_config_i(wt),
    .read_strobe_timing_config_i(alt), .endian_config_i(le),
    .mux_select_i(mux), .pin_hold_enable_i(pen),
    .port_input_buffer_control_i(ibc), .hold_req_n_i(hold_n),
    .data_i(din), .data_o(dout), .data_oe_o(oe), .addr_o(addr),
    .cycle_begin_out_n_o(bs_n), .address_valid_strobe_n_o(as_n),
    .address_hold_out_o(ah), .rd_n_o(rd_n), .rd_wr_o(rd_wr),
    .upper_lane_write_strobe_n_o(wh_n), .lower_lane_write_strobe_n_o(wl_n),
    .area_select_outputs_n_o(cs_n), .dma_acknowledge_n_o(dma_acknowledge_n));

  ebc_mem_model u_mem (.ref_clk_i(clk), .addr_i(addr), .cs_n_i(cs_n),
    .rd_wr_i(rd_wr), .wr_hi_n_i(wh_n), .wr_lo_n_i(wl_n), .begin_n_i(bs_n),
    .wdata_i(dout), .slow_i(slow), .rdata_o(mem_d), .hold_n_o(hold_n));

  task automatic bad(input string m);
    error_cnt++;
    $display("BAD at %0t: %s", $time, m);
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_checks++;
    if (g !== e)
      bad(m);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // counts: 0 select, 1 read strobe, 2 addr strobe, 3 addr hold, 4 pieces, 5 ack
  always @(negedge clk)
  begin
    if (cs_n != 8'hFF)
    begin
      cnt[0]++;
      if (cs_n !== ~(8'h01 << cur_area))
        bad("wrong area select");
      if (!as_n)
        cnt[2]++;
      if (ah)
        cnt[3]++;
    end
    if (!rd_n)
      cnt[1]++;
    if (!dma_acknowledge_n)
      cnt[5]++;
    if (!bs_n && bs_q)
      cnt[4]++;
    bs_q = bs_n;
    if (!rd_n && (cur_wr || rd_wr !== 1'b1))
      bad("read strobe out of place");
    if ((!wh_n || !wl_n) && (!cur_wr || rd_wr !== 1'b0))
      bad("write strobe out of place");
  end

  // config inputs double as the expected configuration
  task automatic set_cfg(input logic [7:0] s, input logic [23:0] w,
    input logic [7:0] a, input logic [7:0] m, input logic p, input logic b);
    @(posedge clk);
    cfg_we <= 1'b1;
    {st, wt, alt, le, mux, pen, ibc} <= {s, w, a, 8'h0F, m, p, b};
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask

  // one access; timing is judged from the counts the watcher gathered
  task automatic access(input logic wr, input ebc_pkg::ebc_size_t sz,
    input logic [23:0] a, input logic [2:0] ar, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    int np;
    int per;
    n = 0;
    while (ready !== 1'b1 && n++ < 100)
      @(negedge clk);
    if (ready !== 1'b1)
      bad("controller never ready");
    {cur_wr, cur_area, cur_dma} = {wr, ar, dma};
    cnt = '{default: 0};
    @(posedge clk);
    {req, req_wr, req_addr} <= {1'b1, wr, a};
    req_sz <= sz;
    {req_area, req_wd, req_dma} <= {ar, wd, dma};
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do
      @(negedge clk);
    while (done !== 1'b1 && n++ < 2000);
    rd = rdata;
    cmp(done, 1'b1, "no completion");
    np = sz == ebc_pkg::SZ_BYTE ? 1 :
         sz == ebc_pkg::SZ_WORD ? 1 + a[0] : 2 + a[0];
    per = st[ar] ? 6 + 2 * wt[3*ar +: 3] : 4;
    cmp(cnt[2] != 0, !mux[ar], "address strobe");
    cmp(cnt[3] != 0, mux[ar], "address hold");
    cmp(cnt[5] != 0, dma, "dma acknowledge");
    if (!mux[ar])
    begin
      cmp(cnt[4], np, "piece count");
      if (!(slow != 0 && st[ar] && pen && ibc))
        cmp(cnt[0], np * per, "cycle length");
      else
        cmp(cnt[0] > np * per && cnt[0] < np * per + 40, 1,
            "pin wait");
      if (!wr)
        cmp(cnt[1], np * (per - 1 - alt[ar]), "read strobe");
    end
  endtask

  // access plus model update; bytes land per the area's endian
  task automatic xfer(input logic wr, input ebc_pkg::ebc_size_t sz,
                      input int a, input logic [2:0] ar);
    logic [31:0] wd;
    logic [31:0] exp;
    logic [31:0] mask;
    int nb;
    int p;
    int s;
    nb = sz == ebc_pkg::SZ_BYTE ? 1 : sz == ebc_pkg::SZ_WORD ? 2 : 4;
    wd = $urandom;
    access(wr, sz, 24'(a), ar, wd, got);
    exp = 32'h00000000;
    mask = nb == 4 ? 32'hFFFFFFFF : (32'h00000001 << (8 * nb)) - 1;
    for (int k = 0; k < nb; k++)
    begin
      p = le[ar] ? (a + k) ^ 1 : a + k;
      s = le[ar] ? 8 * k : 8 * (nb - 1 - k);
      if (wr)
        phys[p] = wd[s +: 8];
      exp[s +: 8] = phys[p];
      if (wr)
        cmp(p % 2 ? u_mem.mem[p / 2][7:0] : u_mem.mem[p / 2][15:8], phys[p],
            "byte lane");
    end
    if (!wr)
      cmp(got & mask, exp, "read data");
  endtask

  // main sequence
  initial
  begin
    int a;
    ebc_pkg::ebc_size_t sz;
    logic [2:0] ar;
    void'($urandom(32'h2add3210));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    @(negedge clk);
    cmp({ready, cs_n, rd_wr, oe}, 11'h7FE, "idle pins after reset");
    slow = 4'h4;
    xfer(1'b1, ebc_pkg::SZ_WORD, 0, 3'h0);
    xfer(1'b0, ebc_pkg::SZ_WORD, 0, 3'h0);
    $display("test reset_defaults done");
    set_cfg(8'hF0, 24'h000000, 8'h00, 8'h00, 1'b1, 1'b1);
    xfer(1'b1, ebc_pkg::SZ_WORD, 16, 3'h1);
    xfer(1'b1, ebc_pkg::SZ_WORD, 16, 3'h5);
    xfer(1'b1, ebc_pkg::SZ_WORD, 16, 3'h7);
    set_cfg(8'hF0, 24'h000000, 8'h00, 8'h00, 1'b1, 1'b0);
    xfer(1'b1, ebc_pkg::SZ_WORD, 16, 3'h5);
    set_cfg(8'hF0, 24'h000000, 8'h00, 8'h00, 1'b0, 1'b1);
    xfer(1'b1, ebc_pkg::SZ_WORD, 16, 3'h5);
    $display("test pin_hold done");
    slow = 4'h0;
    set_cfg(8'hFF, 24'h000000, 8'h00, 8'h04, 1'b0, 1'b0);
    access(1'b1, ebc_pkg::SZ_BYTE, 24'h000800, 3'h2, 32'h0000005A,
           got);
    $display("test multiplexed_area done");
    for (int i = 0; i < 4; i++)
    begin
      set_cfg(8'($urandom), 24'($urandom), 8'($urandom), 8'h00, 1'b1, 1'b1);
      for (int c = 0; c < 12; c++)
      begin
        a = ($urandom_range(0, 255) << 3) | (c % 2);
        sz = ebc_pkg::ebc_size_t'((c / 2) % 3);
        ar = 3'(4 * (c / 6) + $urandom_range(0, 3));
        dma = 1'($urandom_range(0, 1));
        xfer(1'b1, sz, a, ar);
        xfer(1'b0, sz, a, ar);
      end
    end
    $display("test random_mix done");
    give_verdict();
  end

  // watchdog well beyond the expected run length
  initial
  begin
    #(50 * 40000);
    bad("watchdog expired");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
